// ==== hdl/sab_cmd_engine.sv ====
// Parameter block decoder and status block builder behind an APB slave.
//
// Overview of operation
// R01 - Echo parameter tag into every status block.
// R02 - Host keeps concurrent command tags unique.
// R03 - ID FFh runs a board-control command.
// R04 - ID 0 to 15 passes through to SCSI.
// R05 - Word 04h holds ID, options, address, count.
// R06 - Command code at 10h selects operation.
// R07 - Descriptor block content follows ID and code.
// R08 - Fixed status layout: tag, error, flags, info.
// R09 - Single structure gets one final status block.
// R10 - Command list may return several blocks.
// R11 - Flags byte bit layout, bit 1 zero.
// R12 - Target-mode bit only for target responses.
// R13 - Continued bit zero on first block.
// R14 - Over-request bit when device wants more.
// R15 - Short transfer bit when fewer bytes moved.
// R16 - Retried bit when retries were needed.
// R17 - Error bit on any failed command.
// R18 - Adapter-detected errors write an error code.
// R19 - Complete bit set only when finished.
// R20 - Initiator status and sense in info words.
// R21 - Flags byte written after other fields.
//
// The address map and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
module sab_cmd_engine (
    // Clock and reset.
    input  wire logic        pclk,
    input  wire logic        presetn,

    // APB slave.
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,

    // Dispatch towards the SCSI-side executor.
    output logic             disp_valid,
    input  wire logic        disp_ready,
    output logic             disp_board,
    output logic [3:0]       disp_id,
    output logic             disp_list,
    output logic [7:0]       disp_code,
    output logic [31:0]      disp_opt,
    output logic [31:0]      disp_addr,
    output logic [31:0]      disp_count,
    output logic [31:0]      disp_cdb0,
    output logic [31:0]      disp_cdb1,

    // Outcome reports from the executor.
    input  wire logic        res_valid,
    output logic             res_ready,
    input  wire logic        res_final,
    input  wire logic        res_error,
    input  wire logic [7:0]  res_err_code,
    input  wire logic        res_retried,
    input  wire logic        res_short,
    input  wire logic        res_over,
    input  wire logic        res_tms,
    input  wire logic        res_continued,
    input  wire logic [31:0] res_info0,
    input  wire logic [31:0] res_info1
);
    sab_sb_if sb ();                          // Link to the status block writer.

    // Parameter block.
    logic [31:0]        pb [sab_pkg::PB_WORDS];   // Parameter block words.
    logic [31:0]        next_pb [sab_pkg::PB_WORDS];

    // Engine state.
    sab_pkg::sab_state_t state;               // Engine state.
    sab_pkg::sab_state_t next_state;
    sab_pkg::sab_kind_t  kind;                // Kind of the running command.
    sab_pkg::sab_kind_t  next_kind;
    logic               list_mode;            // Command came through a list.
    logic               next_list_mode;
    logic               first_blk;            // No block stored yet for this command.
    logic               next_first_blk;

    // Read path.
    logic [31:0]        next_prdata;
    logic [31:0]        sb_tag;               // Stored status block words.
    logic [31:0]        sb_word1;
    logic [31:0]        sb_info0;
    logic [31:0]        sb_info1;
    logic [7:0]         sb_count;

    // Bus decode.
    logic               wr_cyc;               // APB write in its access phase.
    logic               rd_setup;             // APB read in its setup phase.
    logic               pb_hit;               // Address falls on a parameter word.
    logic [2:0]         pb_idx;               // Parameter word index.

    // Command control.
    logic               start_req;            // Software asks to run the block.
    logic               pass;                 // Running command is a pass-through.
    logic               take_res;             // Executor report is taken.
    logic               store_res;            // Taken report becomes a block.
    logic [7:0]         res_flags;            // Flags built from a report.

    // Status block storage with ordered field writes.
    sab_sb_writer u_writer (
        .pclk     (pclk),
        .presetn  (presetn),
        .sb       (sb.dst),
        .sb_tag   (sb_tag),
        .sb_word1 (sb_word1),
        .sb_info0 (sb_info0),
        .sb_info1 (sb_info1),
        .sb_count (sb_count)
    );

    // The slave answers without wait states.
    assign pready   = 1'b1;

    assign wr_cyc   = psel && penable && pwrite;
    assign rd_setup = psel && !penable && !pwrite;
    assign pb_idx   = paddr[4:2];
    assign pb_hit   = (paddr <= sab_pkg::OFS_PB_LAST) && (paddr[1:0] == 2'b00);

    // Unmapped or misaligned addresses answer with an error.
    always_comb begin
        pslverr = 1'b0;

        if (psel && penable) begin
            if (!pb_hit && paddr != sab_pkg::OFS_CTRL && paddr != sab_pkg::OFS_DECODE
                && paddr != sab_pkg::OFS_SB_TAG && paddr != sab_pkg::OFS_SB_FLAGS
                && paddr != sab_pkg::OFS_SB_INFO0 && paddr != sab_pkg::OFS_SB_INFO1
                && paddr != sab_pkg::OFS_SB_COUNT) begin
                pslverr = 1'b1;
            end
        end
    end

    // A start write is honoured only while the engine is idle.
    assign start_req = wr_cyc && (paddr == sab_pkg::OFS_CTRL)
                       && pwdata[sab_pkg::CTRL_START] && (state == sab_pkg::ST_IDLE);

    // Parameter block words take writes only while idle.
    always_comb begin
        for (int i = 0; i < sab_pkg::PB_WORDS; i++) begin
            next_pb[i] = pb[i];
        end

        if (wr_cyc && pb_hit && state == sab_pkg::ST_IDLE) begin
            // Host fills tag, ID/options/address/count, code and descriptor. [R05] [R07]
            next_pb[pb_idx] = pwdata;
        end
    end

    // Parameter block registers.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < sab_pkg::PB_WORDS; i++) begin
                pb[i] <= sab_pkg::RST_WORD;
            end
        end else begin
            for (int i = 0; i < sab_pkg::PB_WORDS; i++) begin
                pb[i] <= next_pb[i];
            end
        end
    end

    // Read data is picked in the setup phase and held for the access phase.
    always_comb begin
        next_prdata = prdata;

        if (rd_setup) begin
            next_prdata = 32'h0000_0000;
            if (pb_hit) begin
                next_prdata = pb[pb_idx];
            end else begin
                case (paddr)
                    sab_pkg::OFS_CTRL: begin
                        next_prdata[sab_pkg::CTRL_LIST] = list_mode;
                    end
                    sab_pkg::OFS_DECODE: begin
                        next_prdata = {21'h0, state, 2'h0, kind, pb[sab_pkg::PB_IDX_OPT][3:0]};
                    end
                    sab_pkg::OFS_SB_TAG:   next_prdata = sb_tag;
                    sab_pkg::OFS_SB_FLAGS: next_prdata = sb_word1;
                    sab_pkg::OFS_SB_INFO0: next_prdata = sb_info0;
                    sab_pkg::OFS_SB_INFO1: next_prdata = sb_info1;
                    sab_pkg::OFS_SB_COUNT: next_prdata = {24'h0, sb_count};
                    default: begin
                        next_prdata = 32'h0000_0000;
                    end
                endcase
            end
        end
    end

    // Read data register.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= sab_pkg::RST_WORD;
        end else begin
            prdata <= next_prdata;
        end
    end

    // Outcome handshake and flag assembly.
    assign pass      = (kind == sab_pkg::KIND_SCSI);
    assign res_ready = (state == sab_pkg::ST_WAIT) && !sb.busy;
    assign take_res  = res_valid && res_ready;

    // A single structure keeps only the final block; a list keeps every block. [R09] [R10]
    assign store_res = take_res && (res_final || list_mode);

    // Flags byte from an executor report.
    always_comb begin
        res_flags = 8'h00;                                          // Bit 1 stays zero. [R11]
        res_flags[sab_pkg::FLG_CMD_DONE]  = res_final;              // [R19] [R09]
        res_flags[sab_pkg::FLG_ERROR]     = res_error;              // [R17]
        res_flags[sab_pkg::FLG_RETRIED]   = pass && res_retried;    // [R16]
        res_flags[sab_pkg::FLG_SHORT]     = pass && res_short;      // [R15]
        res_flags[sab_pkg::FLG_OVER]      = pass && res_over;       // [R14]
        res_flags[sab_pkg::FLG_CONTINUED] = pass && list_mode
                                            && !first_blk && res_continued; // [R13]
        res_flags[sab_pkg::FLG_TMS]       = pass && res_tms;        // [R12]
    end

    // Block contents handed to the writer.
    always_comb begin
        sb.clear = start_req;
        sb.wr    = 1'b0;
        sb.tag   = pb[sab_pkg::PB_IDX_TAG];                         // [R01]
        sb.err   = 8'h00;
        sb.flags = 8'h00;
        sb.info0 = 32'h0000_0000;
        sb.info1 = 32'h0000_0000;

        if (state == sab_pkg::ST_REPORT) begin
            // Bad ID: the adapter reports its own error and completes. [R18] [R17]
            sb.wr    = !sb.busy;
            sb.err   = sab_pkg::ERR_BAD_ID;
            sb.flags[sab_pkg::FLG_CMD_DONE] = 1'b1;
            sb.flags[sab_pkg::FLG_ERROR]    = 1'b1;
        end else if (store_res) begin
            sb.wr    = 1'b1;
            sb.err   = res_error ? res_err_code : 8'h00;            // [R18]
            sb.flags = res_flags;
            sb.info0 = res_info0;                                   // SCSI status and sense. [R20]
            sb.info1 = res_info1;                                   // [R20]
        end
    end

    // Dispatch ID and code come straight from the stored parameter block; board and list flags come from engine state.
    assign disp_valid = (state == sab_pkg::ST_DISPATCH);

    assign disp_board = (kind == sab_pkg::KIND_BOARD);              // [R03]
    assign disp_id    = pb[sab_pkg::PB_IDX_OPT][3:0];               // [R04]
    assign disp_list  = list_mode;
    assign disp_code  = pb[sab_pkg::PB_IDX_CODE][7:0];              // [R06]

    // Raw parameter words.
    assign disp_opt   = pb[sab_pkg::PB_IDX_OPT];                    // [R05]
    assign disp_addr  = pb[sab_pkg::PB_IDX_ADDR];
    assign disp_count = pb[sab_pkg::PB_IDX_COUNT];
    assign disp_cdb0  = pb[sab_pkg::PB_IDX_CDB0];                   // [R07]
    assign disp_cdb1  = pb[sab_pkg::PB_IDX_CDB1];

    // Engine sequencing.
    always_comb begin
        next_state     = state;
        next_kind      = kind;
        next_list_mode = list_mode;
        next_first_blk = first_blk;

        case (state)
            sab_pkg::ST_IDLE: begin
                if (start_req) begin
                    // Latch structure type; flags cleared before execution. [R19]
                    next_list_mode = pwdata[sab_pkg::CTRL_LIST];
                    next_first_blk = 1'b1;
                    next_state     = sab_pkg::ST_DECODE;
                end
            end

            sab_pkg::ST_DECODE: begin
                // ID byte selects board-control, pass-through or error. [R03] [R04]
                next_kind = sab_pkg::sab_id_kind(pb[sab_pkg::PB_IDX_OPT][7:0]);

                if (next_kind == sab_pkg::KIND_BAD) begin
                    next_state = sab_pkg::ST_REPORT;
                end else begin
                    next_state = sab_pkg::ST_DISPATCH;
                end
            end

            sab_pkg::ST_DISPATCH: begin
                // The request holds until taken.
                if (disp_ready) begin
                    next_state = sab_pkg::ST_WAIT;
                end
            end

            sab_pkg::ST_WAIT: begin
                if (store_res) begin
                    next_first_blk = 1'b0;
                end
                // The final report ends it.
                if (take_res && res_final) begin
                    next_state = sab_pkg::ST_IDLE;
                end
            end

            sab_pkg::ST_REPORT: begin
                // Waits for a free writer.
                if (!sb.busy) begin
                    next_state = sab_pkg::ST_IDLE;
                end
            end

            default: begin
                next_state = sab_pkg::ST_IDLE;
            end
        endcase
    end

    // Engine state registers.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // No command runs after reset.
            state     <= sab_pkg::ST_IDLE;
            kind      <= sab_pkg::KIND_BOARD;
            list_mode <= 1'b0;
            first_blk <= 1'b1;
        end else begin
            state     <= next_state;
            kind      <= next_kind;
            list_mode <= next_list_mode;
            first_blk <= next_first_blk;
        end
    end
endmodule : sab_cmd_engine

// ==== include/sab_pkg.sv ====
// Shared constants, types and decode helpers of the command/status block engine.
package sab_pkg;
    // Register byte offsets on the APB side.
    localparam logic [11:0] OFS_PB_BASE  = 12'h000; // Parameter block words 0x00 to 0x18.
    localparam logic [11:0] OFS_PB_LAST  = 12'h018; // Last parameter block word.
    localparam logic [11:0] OFS_CTRL     = 12'h020; // Start and structure mode.
    localparam logic [11:0] OFS_DECODE   = 12'h024; // Engine state, decoded kind and ID.
    localparam logic [11:0] OFS_SB_TAG   = 12'h040; // Status block word 0x00.
    localparam logic [11:0] OFS_SB_FLAGS = 12'h044; // Status block word 0x04.
    localparam logic [11:0] OFS_SB_INFO0 = 12'h048; // Status block word 0x08.
    localparam logic [11:0] OFS_SB_INFO1 = 12'h04C; // Status block word 0x0C.
    localparam logic [11:0] OFS_SB_COUNT = 12'h050; // Status blocks delivered so far.
    // Parameter block word indices.
    localparam int unsigned PB_WORDS     = 7;
    localparam logic [2:0]  PB_IDX_TAG   = 3'h0;
    localparam logic [2:0]  PB_IDX_OPT   = 3'h1;
    localparam logic [2:0]  PB_IDX_ADDR  = 3'h2;
    localparam logic [2:0]  PB_IDX_COUNT = 3'h3;
    localparam logic [2:0]  PB_IDX_CODE  = 3'h4;
    localparam logic [2:0]  PB_IDX_CDB0  = 3'h5;
    localparam logic [2:0]  PB_IDX_CDB1  = 3'h6;
    // Control register bit positions.
    localparam int unsigned CTRL_START   = 0;
    localparam int unsigned CTRL_LIST    = 1;
    // Target/adapter ID values.
    localparam logic [7:0]  ID_BOARD     = 8'hFF;
    localparam logic [7:0]  ID_SCSI_MAX  = 8'h0F;
    // Status word field positions: error in byte 2, flags in byte 3.
    localparam int unsigned SB_ERR_LSB   = 16;
    localparam int unsigned SB_FLG_LSB   = 24;
    // Flags byte bit positions.
    localparam int unsigned FLG_CMD_DONE  = 7;
    localparam int unsigned FLG_ERROR     = 6;
    localparam int unsigned FLG_RETRIED   = 5;
    localparam int unsigned FLG_SHORT     = 4;
    localparam int unsigned FLG_OVER      = 3;
    localparam int unsigned FLG_CONTINUED = 2;
    localparam int unsigned FLG_TMS       = 0;
    // Reset values.
    localparam logic [31:0] RST_WORD     = 32'h0000_0000;
    localparam logic [7:0]  RST_COUNT    = 8'h00;
    // Error code written for an ID outside both valid ranges.
    localparam logic [7:0]  ERR_BAD_ID   = 8'h01;

    // Decoded command kind.
    typedef enum logic [1:0] {
        KIND_BOARD = 2'b00,
        KIND_SCSI  = 2'b01,
        KIND_BAD   = 2'b10
    } sab_kind_t;

    // Engine sequencing states.
    typedef enum logic [2:0] {
        ST_IDLE     = 3'b000,
        ST_DECODE   = 3'b001,
        ST_DISPATCH = 3'b010,
        ST_WAIT     = 3'b011,
        ST_REPORT   = 3'b100
    } sab_state_t;

    // Classifies a target/adapter ID byte.
    function automatic sab_kind_t sab_id_kind(input logic [7:0] id);
        if (id == ID_BOARD) begin
            return KIND_BOARD;
        end else if (id <= ID_SCSI_MAX) begin
            return KIND_SCSI;
        end
        return KIND_BAD;
    endfunction : sab_id_kind
endpackage : sab_pkg

// ==== include/sab_sb_if.sv ====
// Carrier between the command engine and the status block writer.
`timescale 1ns/1ps
interface sab_sb_if;
    logic        clear;  // Pulse: a new command starts, flags drop to zero.
    logic        wr;     // Pulse: write one status block.
    logic        busy;   // Writer is storing a block.
    logic [31:0] tag;    // Command tag to echo.
    logic [7:0]  err;    // Error code byte.
    logic [7:0]  flags;  // Flags byte.
    logic [31:0] info0;  // Status information word 0x08.
    logic [31:0] info1;  // Status information word 0x0C.
    modport src (output clear, wr, tag, err, flags, info0, info1, input busy);
    modport dst (input clear, wr, tag, err, flags, info0, info1, output busy);
endinterface : sab_sb_if

// ==== hdl/sab_sb_writer.sv ====
// Status block store that lands the flags byte after all other fields.
`timescale 1ns/1ps
module sab_sb_writer (
    input  wire logic  pclk,
    input  wire logic  presetn,
    sab_sb_if.dst      sb,
    output logic [31:0] sb_tag,
    output logic [31:0] sb_word1,
    output logic [31:0] sb_info0,
    output logic [31:0] sb_info1,
    output logic [7:0]  sb_count
);
    logic        phase;       // High in the cycle that stores the flags byte.
    logic        next_phase;  // Next phase.
    logic [7:0]  flg_hold;    // Flags waiting for their own write cycle.
    logic [7:0]  next_flg_hold;
    logic [31:0] next_tag;
    logic [31:0] next_word1;
    logic [31:0] next_info0;
    logic [31:0] next_info1;
    logic [7:0]  next_count;

    assign sb.busy = phase;

    // Fields first, then the flags byte one cycle later.
    always_comb begin
        next_phase    = 1'b0;
        next_flg_hold = flg_hold;
        next_tag      = sb_tag;
        next_word1    = sb_word1;
        next_info0    = sb_info0;
        next_info1    = sb_info1;
        next_count    = sb_count;
        if (sb.clear) begin
            // A new command restarts the block count with complete clear. [R19]
            next_word1 = sab_pkg::RST_WORD;
            next_count = sab_pkg::RST_COUNT;
        end else if (phase) begin
            // The flags byte lands last, so polling never sees stale fields. [R21]
            next_word1[sab_pkg::SB_FLG_LSB +: 8] = flg_hold;
            next_count = sb_count + 8'h01;
        end else if (sb.wr) begin
            // Tag echo, error byte and status words go first. [R01] [R08] [R21]
            next_tag   = sb.tag;
            next_word1[sab_pkg::SB_ERR_LSB +: 8] = sb.err;
            next_info0 = sb.info0;
            next_info1 = sb.info1;
            next_flg_hold = sb.flags;
            next_phase = 1'b1;
        end
    end

    // Registers of the status block.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase    <= 1'b0;
            flg_hold <= 8'h00;
            sb_tag   <= sab_pkg::RST_WORD;
            sb_word1 <= sab_pkg::RST_WORD;
            sb_info0 <= sab_pkg::RST_WORD;
            sb_info1 <= sab_pkg::RST_WORD;
            sb_count <= sab_pkg::RST_COUNT;
        end else begin
            phase    <= next_phase;
            flg_hold <= next_flg_hold;
            sb_tag   <= next_tag;
            sb_word1 <= next_word1;
            sb_info0 <= next_info0;
            sb_info1 <= next_info1;
            sb_count <= next_count;
        end
    end
endmodule : sab_sb_writer

// ==== sim/sab_cmd_engine_monitor.sv ====
// Concurrent checks on the ports of the command engine.
`timescale 1ns/1ps
module sab_cmd_engine_monitor (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        disp_valid,
    input wire logic        disp_ready,
    input wire logic        disp_board,
    input wire logic [3:0]  disp_id,
    input wire logic [7:0]  disp_code,
    input wire logic        disp_list,
    input wire logic        res_valid,
    input wire logic        res_ready,
    input wire logic        res_final
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [7:0] id_q;   // Last ID byte written by the host.
    logic       st_wr;  // Access phase of a start write.
    assign st_wr = psel && penable && pwrite && paddr == 12'h020 && pwdata[0];
    // Shadow of the ID byte.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            id_q <= 8'h00;
        end else if (psel && penable && pwrite && paddr == 12'h004) begin
            id_q <= pwdata[7:0];
        end
    end
    chk_ready_const: assert property (pready) else $error("pready low");
    chk_err_phase: assert property (pslverr |-> psel && penable)
        else $error("pslverr outside access");
    chk_err_rdata: assert property (pslverr && !pwrite |-> prdata == 32'h0)
        else $error("unmapped read not zero");
    chk_disp_hold: assert property (disp_valid && !disp_ready |=> disp_valid
        && $stable(disp_code) && $stable(disp_id)) else $error("dispatch dropped");
    chk_disp_route: assert property (disp_valid |-> disp_id == id_q[3:0]
        && disp_board == (id_q == 8'hFF)) else $error("dispatch route wrong");
    chk_bad_id: assert property (disp_valid |-> id_q == 8'hFF || id_q <= 8'h0F)
        else $error("bad ID dispatched");
    chk_disp_start: assert property ($rose(disp_valid) |-> $past(st_wr, 2))
        else $error("dispatch not two cycles after start");
    chk_wait_ready: assert property (disp_valid && disp_ready |=> res_ready)
        else $error("no result wait after dispatch");
    chk_res_gap: assert property (res_valid && res_ready && (res_final || disp_list)
        |=> !res_ready) else $error("result taken while storing");
    cover property (disp_valid && !disp_ready);
    cover property (res_valid && res_ready && res_final);
    cover property (pslverr);
endmodule : sab_cmd_engine_monitor
bind sab_cmd_engine sab_cmd_engine_monitor u_mon (.*);

// ==== sim/sab_exec_model.sv ====
// Behavioural SCSI-side executor that takes dispatches and returns reports.
`timescale 1ns/1ps
module sab_exec_model (
    input wire logic       pclk,
    input wire logic [3:0] dly,
    input wire logic [1:0] nrep,
    input wire logic       disp_valid,
    input wire logic       res_ready,
    output logic           disp_ready,
    output logic           res_valid,
    output logic           res_final
);
    int k;  // Report number within a command.
    // Stalls dly cycles before each answer; sends nrep reports, last one final.
    initial begin
        disp_ready = 1'b0;
        res_valid = 1'b0;
        res_final = 1'b0;
        forever begin
            @(posedge pclk);
            if (disp_valid === 1'b1) begin
                repeat (dly) @(posedge pclk);
                disp_ready <= 1'b1;
                @(posedge pclk);
                disp_ready <= 1'b0;
                for (k = 1; k <= nrep; k++) begin
                    repeat (dly) @(posedge pclk);
                    res_valid <= 1'b1;
                    res_final <= (k == nrep);
                    do @(posedge pclk); while (res_ready !== 1'b1);
                    res_valid <= 1'b0;
                    res_final <= ~res_final;
                end
            end
        end
    end
endmodule : sab_exec_model

// ==== sim/tb_scsi_adapter_cmd_status_blocks.sv ====
// Random and corner-case bench for the command/status block engine.
`timescale 1ns/1ps
module tb_scsi_adapter_cmd_status_blocks;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, disp_valid, disp_ready;
    logic disp_board, disp_list, res_valid, res_ready, res_final, res_error, res_retried;
    logic res_short, res_over, res_tms, res_continued, lst;
    logic [11:0] paddr;
    logic [7:0] disp_code, res_err_code;
    logic [3:0] disp_id, dly;
    logic [1:0] nrep;
    logic [31:0] pwdata, prdata, disp_opt, disp_addr, disp_count, disp_cdb0, disp_cdb1;
    logic [31:0] res_info0, res_info1;
    int n_errors, comparisons, j;
    logic [7:0] j_ids [4] = '{8'h00, 8'h0F, 8'h10, 8'hFE};  // Boundary ID values.
    sab_cmd_engine dut (.*);
    sab_exec_model u_exec (.*);
    // Clock at 100 MHz.
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // Prints the verdict and ends the run.
    task stop_test;
        if (n_errors == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : stop_test
    // Compares a seen value against the expected one.
    task check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    // One APB transfer; holds the request until pready is sampled high.
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
             output logic [31:0] q);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb
    // Expected {flags, error} of the last stored block.
    function automatic logic [15:0] exp_sw(input logic [7:0] id);
        logic b;
        b = (id == 8'hFF);
        if (!b && id > 8'h0F) return 16'hC001;
        return {1'b1, res_error, res_retried & ~b, res_short & ~b, res_over & ~b,
                res_continued & ~b & lst & (nrep > 2'd1), 1'b0, res_tms & ~b,
                res_error ? res_err_code : 8'h00};
    endfunction : exp_sw
    // Issues one command with random contents and checks the stored block.
    task run_cmd(input logic [7:0] id);
        logic [31:0] q, tg;
        int i;
        tg = $urandom;
        @(posedge pclk);
        {res_error, res_retried, res_short, res_over, res_tms, res_continued} <= 6'($urandom);
        {lst, res_err_code, res_info0, res_info1} <= 73'({$urandom, $urandom, $urandom});
        nrep <= 2'(1 + $urandom_range(2));
        dly <= 4'(2 + $urandom_range(3));
        apb(1'b1, 12'h000, tg, q);
        apb(1'b1, 12'h004, {24'($urandom), id}, q);
        apb(1'b1, 12'h010, $urandom, q);
        apb(1'b1, 12'h020, {30'h0, lst, 1'b1}, q);
        apb(1'b0, 12'h044, 32'h0, q);
        check(q[31:24], 32'h0);
        i = 0;
        do begin
            apb(1'b0, 12'h024, 32'h0, q);
            i++;
        end while (q[10:8] !== 3'h0 && i < 200);
        check(32'(q[10:8]), 32'h0);
        apb(1'b0, 12'h040, 32'h0, q);
        check(q, tg);
        apb(1'b0, 12'h044, 32'h0, q);
        check(q[31:16], exp_sw(id));
        if (id == 8'hFF || id <= 8'h0F) begin
            apb(1'b0, 12'h048, 32'h0, q);
            check(q, res_info0);
            apb(1'b0, 12'h04C, 32'h0, q);
            check(q, res_info1);
        end
        apb(1'b0, 12'h050, 32'h0, q);
        check(q, (id != 8'hFF && id > 8'h0F) || !lst ? 32'h1 : 32'(nrep));
    endtask : run_cmd
    // Cuts a hang short.
    initial begin
        repeat (40000) @(posedge pclk);
        n_errors++;
        stop_test;
    end
    // Main sequence.
    initial begin
        logic [31:0] q;
        n_errors = 0; comparisons = 0;
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 12'h000; pwdata = 32'h0; lst = 1'b0; nrep = 2'd1; dly = 4'd2;
        {res_error, res_retried, res_short, res_over, res_tms, res_continued} = 6'h00;
        res_err_code = 8'h00; res_info0 = 32'h0; res_info1 = 32'h0;
        j = $urandom(90571);
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 12'h044, 32'h0, q);
        check(q, 32'h0);
        apb(1'b0, 12'h030, 32'h0, q);
        foreach (j_ids[k]) run_cmd(j_ids[k]);
        for (j = 0; j < 16; j++) begin
            run_cmd(($urandom % 3 == 0) ? 8'hFF : 8'($urandom_range(15)));
        end
        stop_test;
    end
endmodule : tb_scsi_adapter_cmd_status_blocks
